// File: pm_aux_field.sv
// Auxiliary current field qualification
module pm_aux_field (
	input wire logic d3cold_wake_i,
	input wire logic has_data_reg_i,
	input wire logic [2:0] aux_code_i,
	output logic [2:0] aux_o
);
	// zero unless D3cold wake without data register
	assign aux_o = (d3cold_wake_i && !has_data_reg_i) ? aux_code_i : pm_caps_pkg::AUX_SELF;
endmodule

// File: pm_caps_pkg.sv
// Constants for the power management capabilities word
// Function
// - Bits 15:11 are per-state wake support mask
// - Bit 10 set only when D2 supported
// - Bit 9 set only when D1 supported
// - Data register present forces aux current zero
// - No D3cold wake forces aux current zero
// - Aux current code encodes maximum auxiliary draw
// - Bit 5 flags device-specific initialization need
// - Bit 3 flags wake needing bus clock
// - No wake anywhere forces bit 3 zero
// - Version field reads 010b
// - Strap pin sampled at power-on sets defaults
// - Strap high sets bit 15, else zero
// - Fixed wake and D2 bits per function
package pm_caps_pkg;
	localparam int WAKE_MSB = 15;
	localparam int WAKE_LSB = 11;
	localparam int WAKE_D3COLD = 4;
	localparam int D2_BIT = 10;
	localparam int D1_BIT = 9;
	localparam int AUX_MSB = 8;
	localparam int AUX_LSB = 6;
	localparam int DSI_BIT = 5;
	localparam int RSVD_BIT = 4;
	localparam int CLK_BIT = 3;
	localparam int VER_MSB = 2;
	localparam int VER_LSB = 0;
	localparam logic [2:0] AUX_SELF = 3'h0;
	localparam logic [2:0] AUX_375MA = 3'h7;
	localparam logic [2:0] VERSION_1_1 = 3'h2;
	// Fixed wake bits D0..D3hot: both full-speed and high-speed variants
	localparam logic [3:0] WAKE_FIXED_FS = 4'hA;
	localparam logic [3:0] WAKE_FIXED_HS = 4'hF;
	// Config byte address of the capability structure and offset of the word within it
	localparam logic [7:0] CAP_BASE = 8'h34;
	localparam logic [7:0] CAPS_OFFSET = 8'h02;
	// Strap settle counter: capture point and final count
	localparam logic [1:0] STRAP_CAPTURE_AT = 2'h2;
	localparam logic [1:0] STRAP_SETTLE_END = 2'h3;
endpackage

// File: pm_caps_word.sv
// Read-only power management capabilities word with strap-set default
module pm_caps_word #(
	parameter bit IS_HIGH_SPEED = 1'b0,
	parameter bit HAS_DATA_REG = 1'b0,
	parameter logic [2:0] AUX_CODE = pm_caps_pkg::AUX_375MA,
	parameter bit NEEDS_DSI = 1'b0,
	parameter bit WAKE_NEEDS_CLK = 1'b0
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic port4_amber_led_strap_i,
	input wire logic cfg_rd_i,
	input wire logic cfg_wr_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [15:0] cfg_wdata_i,
	output logic [15:0] power_caps_word_o,
	output logic [15:0] cfg_rdata_o,
	output logic cfg_ack_o
);
	logic strap_level;
	logic strap_valid;
	logic d3cold_wake;
	logic [2:0] aux_field;
	logic [4:0] wake_state_support_mask;
	logic d2_state_supported;
	logic d1_state_supported;
	logic wake_needs_bus_clock;
	logic [2:0] pm_interface_version;
	logic hit;
	logic [15:0] next_word;

	// ****************************************
	// Strap capture
	// ****************************************
	pm_strap_sync u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.strap_i(port4_amber_led_strap_i),
		.captured_o(strap_level),
		.valid_o(strap_valid)
	);

	assign d3cold_wake = strap_level;

	pm_aux_field u_aux (
		.d3cold_wake_i(d3cold_wake),
		.has_data_reg_i(HAS_DATA_REG),
		.aux_code_i(AUX_CODE),
		.aux_o(aux_field)
	);

	// ****************************************
	// Field assembly
	// ****************************************
	// wake mask with fixed lower bits
	assign wake_state_support_mask = {d3cold_wake,
		IS_HIGH_SPEED ? pm_caps_pkg::WAKE_FIXED_HS : pm_caps_pkg::WAKE_FIXED_FS};
	assign d2_state_supported = IS_HIGH_SPEED;
	assign d1_state_supported = 1'b1;
	// clock bit zero without any wake
	assign wake_needs_bus_clock = WAKE_NEEDS_CLK && (wake_state_support_mask != 5'h00);
	assign pm_interface_version = pm_caps_pkg::VERSION_1_1;

	assign next_word = {wake_state_support_mask, d2_state_supported, d1_state_supported,
		aux_field, NEEDS_DSI, 1'b0, wake_needs_bus_clock, pm_interface_version};

	// ****************************************
	// Configuration access decode
	// ****************************************
	logic [7:0] caps_addr;
	logic rd_hit;
	logic any_access;
	// Sum cut to the address width on purpose
	assign caps_addr = 8'(pm_caps_pkg::CAP_BASE + pm_caps_pkg::CAPS_OFFSET);
	assign hit = (cfg_addr_i == caps_addr);
	assign rd_hit = cfg_rd_i && hit;
	assign any_access = cfg_rd_i | cfg_wr_i;

	// ****************************************
	// Capability word register
	// ****************************************
	// word loads once strap captured; writes never touch it
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			power_caps_word_o <= 16'h0000;
		end else if (strap_valid) begin
			power_caps_word_o <= next_word;
		end
	end

	// ****************************************
	// Read answer
	// ****************************************
	// reads of the word address return word, other reads zero; writes acknowledged and discarded
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_rdata_o <= 16'h0000;
			cfg_ack_o <= 1'b0;
		end else begin
			cfg_ack_o <= any_access;
			cfg_rdata_o <= rd_hit ? power_caps_word_o : 16'h0000;
		end
	end

	// ****************************************
	// Write data sink
	// ****************************************
	// Writes are answered but their data is never stored
	logic unused_wdata;
	assign unused_wdata = ^cfg_wdata_i;

	// ****************************************
	// Assertion helpers
	// ****************************************
	// Marks the cycles after the word took its strapped value
	logic word_loaded;
	// Wake bits for D0 to D3hot as the function must report them
	logic [3:0] fixed_wake;
	// Wake mask field as a whole
	logic [4:0] wake_field;
	// Auxiliary current field as a whole
	logic [2:0] aux_read;

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			word_loaded <= 1'b0;
		end else if (strap_valid) begin
			word_loaded <= 1'b1;
		end
	end

	assign fixed_wake = IS_HIGH_SPEED ? pm_caps_pkg::WAKE_FIXED_HS : pm_caps_pkg::WAKE_FIXED_FS;
	assign wake_field = power_caps_word_o[pm_caps_pkg::WAKE_MSB:pm_caps_pkg::WAKE_LSB];
	assign aux_read = power_caps_word_o[pm_caps_pkg::AUX_MSB:pm_caps_pkg::AUX_LSB];

	// ****************************************
	// Access sequences
	// ****************************************
	// A read that addresses the word
	sequence read_request_s;
		rd_hit;
	endsequence

	// The answer one cycle later carries the word
	sequence read_answer_s;
		cfg_ack_o && (cfg_rdata_o == $past(power_caps_word_o));
	endsequence

	// A lone request followed by an idle cycle
	sequence lone_access_s;
		any_access ##1 !any_access;
	endsequence

	// Acknowledge high for exactly one cycle
	sequence ack_pulse_s;
		cfg_ack_o ##1 !cfg_ack_o;
	endsequence

	// ****************************************
	// Field assertions
	// ****************************************
	// aux zero without D3cold wake
	aux_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		!power_caps_word_o[pm_caps_pkg::WAKE_MSB] |-> aux_read == pm_caps_pkg::AUX_SELF)
		else $error("aux current nonzero without D3cold wake");

	version_field_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		strap_valid |=>
		power_caps_word_o[pm_caps_pkg::VER_MSB:pm_caps_pkg::VER_LSB] == pm_caps_pkg::VERSION_1_1)
		else $error("version field wrong");

	reserved_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		power_caps_word_o[pm_caps_pkg::RSVD_BIT] == 1'b0)
		else $error("reserved bit set");

	strap_bit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		strap_valid |=> power_caps_word_o[pm_caps_pkg::WAKE_MSB] == $past(strap_level))
		else $error("D3cold bit does not follow strap");

	write_ignored_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		word_loaded && cfg_wr_i |=> $stable(power_caps_word_o))
		else $error("write changed word");

	d2_bit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		strap_valid |=> power_caps_word_o[pm_caps_pkg::D2_BIT] == IS_HIGH_SPEED)
		else $error("D2 bit wrong");

	d1_bit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		strap_valid |=> power_caps_word_o[pm_caps_pkg::D1_BIT])
		else $error("D1 bit wrong");

	wake_mask_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		word_loaded |-> wake_field[pm_caps_pkg::WAKE_D3COLD - 1:0] == fixed_wake)
		else $error("fixed wake bits wrong");

	wake_x_bits_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		word_loaded |-> (power_caps_word_o[pm_caps_pkg::WAKE_LSB + 2] ==
		power_caps_word_o[pm_caps_pkg::D2_BIT]) &&
		(power_caps_word_o[pm_caps_pkg::WAKE_LSB] == power_caps_word_o[pm_caps_pkg::D2_BIT]))
		else $error("strap-independent bits disagree");

	// aux code with D3cold wake and no data register
	aux_code_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		word_loaded && power_caps_word_o[pm_caps_pkg::WAKE_MSB] && !HAS_DATA_REG |->
		aux_read == AUX_CODE)
		else $error("aux current code wrong");

	data_reg_aux_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		HAS_DATA_REG |-> aux_read == pm_caps_pkg::AUX_SELF)
		else $error("aux current nonzero with data register");

	dsi_bit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		word_loaded |-> power_caps_word_o[pm_caps_pkg::DSI_BIT] == NEEDS_DSI)
		else $error("initialization flag wrong");

	clk_bit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		word_loaded && wake_field != 5'h00 |->
		power_caps_word_o[pm_caps_pkg::CLK_BIT] == WAKE_NEEDS_CLK)
		else $error("clock dependence bit wrong");

	// no wake means no clock bit
	no_wake_clk_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		wake_field == 5'h00 |-> !power_caps_word_o[pm_caps_pkg::CLK_BIT])
		else $error("clock bit set without wake");

	unloaded_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		!word_loaded |-> power_caps_word_o == 16'h0000)
		else $error("word set before strap capture");

	word_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		word_loaded |=> $stable(power_caps_word_o))
		else $error("word changed after load");

	strap_once_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		word_loaded |-> strap_valid)
		else $error("strap capture lost");

	// ****************************************
	// Access assertions
	// ****************************************
	// read answer carries the word
	read_data_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		read_request_s |=> read_answer_s)
		else $error("read data mismatch");

	ack_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		lone_access_s |-> ack_pulse_s)
		else $error("acknowledge not a single pulse");

	miss_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		cfg_rd_i && !hit |=> cfg_ack_o && cfg_rdata_o == 16'h0000)
		else $error("read elsewhere returned data");

	write_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		cfg_wr_i && !cfg_rd_i |=> cfg_ack_o && cfg_rdata_o == 16'h0000)
		else $error("write returned data");

	idle_ack_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		!any_access |=> !cfg_ack_o)
		else $error("acknowledge without request");

	rdata_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		!cfg_ack_o |-> cfg_rdata_o == 16'h0000)
		else $error("read data without acknowledge");
endmodule

// File: pm_caps_word_tb_top.sv
// Self-checking bench for the capabilities word
module pm_caps_word_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic strap = 1'b0;
	logic rd, wr, ack;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, word, hs_word, opt_word, cur;
	logic [15:0] exp_q[$];
	logic [31:0] seed = 32'h00010841;
	int n_errors = 0;
	int n_tests = 0;
	pm_host_model host (.sys_clk_i(sys_clk_i), .rd_o(rd), .wr_o(wr), .addr_o(addr),
		.wdata_o(wdata));
	pm_caps_word uut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .port4_amber_led_strap_i(strap),
		.cfg_rd_i(rd), .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
		.power_caps_word_o(word), .cfg_rdata_o(rdata), .cfg_ack_o(ack));
	pm_caps_word #(.IS_HIGH_SPEED(1'b1)) uut_hs (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.port4_amber_led_strap_i(strap), .cfg_rd_i(rd), .cfg_wr_i(wr), .cfg_addr_i(addr),
		.cfg_wdata_i(wdata), .power_caps_word_o(hs_word), .cfg_rdata_o(), .cfg_ack_o());
	pm_caps_word #(.HAS_DATA_REG(1'b1), .NEEDS_DSI(1'b1), .WAKE_NEEDS_CLK(1'b1)) uut_opt (
		.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .port4_amber_led_strap_i(strap),
		.cfg_rd_i(rd), .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
		.power_caps_word_o(opt_word), .cfg_rdata_o(), .cfg_ack_o());
	initial begin
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	// Each ack takes the oldest expected read value
	always @(negedge sys_clk_i) begin
		if (ack === 1'b1) begin
			if (exp_q.size() == 0) check("cfg_ack_o", 16'h0000, 16'h0001);
			else check("cfg_rdata_o", exp_q.pop_front(), rdata);
		end
	end
	task automatic op(input logic w, input logic [7:0] a);
		exp_q.push_back((!w && a == 8'h36) ? cur : 16'h0000);
		seed = xs(seed);
		host.access(w, a, seed[15:0]);
	endtask
	task automatic run(input logic s, input logic [15:0] fs, input logic [15:0] hs,
		input logic [15:0] ow);
		int i;
		#2;
		rst_b_i = 1'b0;
		strap = s;
		cur = fs;
		repeat (10) @(posedge sys_clk_i);
		#2;
		check("word in reset", 16'h0000, word);
		rst_b_i = 1'b1;
		repeat (4) @(posedge sys_clk_i);
		#2;
		check("power_caps_word_o", fs, word);
		check("high speed word", hs, hs_word);
		check("option word", ow, opt_word);
		op(1'b0, 8'h36);
		op(1'b1, 8'h36);
		op(1'b0, 8'h36);
		for (i = 0; i < 10; i++) begin
			seed = xs(seed);
			op(seed[0], seed[1] ? 8'h36 : seed[15:8]);
		end
		for (i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge sys_clk_i);
		if (exp_q.size() != 0) begin
			n_errors++;
			tally_and_finish();
		end
		check("word after writes", fs, word);
		$display("test strap=%0d done", s);
	endtask
	task automatic tally_and_finish();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		run(1'b1, 16'hD3C2, 16'hFFC2, 16'hD22A);
		run(1'b0, 16'h5202, 16'h7E02, 16'h522A);
		tally_and_finish();
	end
endmodule

// File: pm_host_model.sv
// Host model issuing one-cycle configuration accesses
module pm_host_model (
	input wire logic sys_clk_i,
	output logic rd_o,
	output logic wr_o,
	output logic [7:0] addr_o,
	output logic [15:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 16'h0000;
	end
	// Released address and data lines show inverted values, not the last ones; rd_o and wr_o drop to zero
	task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		#2;
		rd_o = ~w;
		wr_o = w;
		addr_o = a;
		wdata_o = d;
		@(posedge sys_clk_i);
		#2;
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask
endmodule

// File: pm_strap_sync.sv
// Two-stage synchroniser and power-on capture for the strap pin
module pm_strap_sync (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic strap_i,
	output logic captured_o,
	output logic valid_o
);
	logic meta;
	logic stable;
	logic [1:0] settle;

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta <= 1'b0;
			stable <= 1'b0;
		end else begin
			meta <= strap_i;
			stable <= meta;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			settle <= 2'h0;
			captured_o <= 1'b0;
			valid_o <= 1'b0;
		end else if (settle != pm_caps_pkg::STRAP_SETTLE_END) begin
			settle <= 2'(settle + 2'h1);
			if (settle == pm_caps_pkg::STRAP_CAPTURE_AT) begin
				captured_o <= stable;
				valid_o <= 1'b1;
			end
		end
	end
endmodule
